// ===== pwm_load.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
  // clock and pin
  input  wire logic        i_sys_clk,
  input  wire logic        i_pwm_output_pin,
  input  wire logic        i_pwm_oe_n,
  // measured waveform
  output logic             o_level,
  output logic             o_rise,
  output logic [15:0]      o_high_cycles,
  output logic [15:0]      o_period_cycles
);
  logic        held = 1'b0;
  logic        prev = 1'b0;
  logic [15:0] hcnt = 16'h0000;
  logic [15:0] pcnt = 16'h0000;
  // a released pin shows no stale level: inverse of what was last driven
  assign o_level = i_pwm_oe_n ? ~held : i_pwm_output_pin;
  // o_rise only reports edges while the pin is driven; the counts follow o_level at all times
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_pwm_oe_n) held <= i_pwm_output_pin;
    prev <= o_level;
    o_rise <= o_level && !prev && !i_pwm_oe_n;
    hcnt <= o_level ? hcnt + 16'h0001 : 16'h0000;
    pcnt <= (o_level && !prev) ? 16'h0001 : pcnt + 16'h0001;
    if (!o_level && prev) o_high_cycles <= hcnt;
    if (o_level && !prev) o_period_cycles <= pcnt;
  end
endmodule : pwm_load
`default_nettype wire

// ===== pwm_pkg.sv
package pwm_pkg;
  // timer resources and widths
  localparam int          NUM_TIMERS     = 3;
  localparam int          TIMER_W        = 8;
  localparam int          DUTY_W         = 10;
  // module control register layout
  localparam int          CTRL_DUTY_LSB  = 4;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam logic [1:0]  MODE_PWM_TOP   = 2'h3;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  DUTY_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_RESET    = 8'h00;
  // prescale codes and their last prescaler count
  localparam logic [1:0]  PSC_DIV1       = 2'h0;
  localparam logic [1:0]  PSC_DIV4       = 2'h1;
  localparam logic [3:0]  PSC_LAST_DIV1  = 4'h0;
  localparam logic [3:0]  PSC_LAST_DIV4  = 4'h3;
  localparam logic [3:0]  PSC_LAST_DIV16 = 4'hF;
  // one timer step spans four oscillator periods
  localparam int          TOSC_NS        = 8;
  localparam int          SYS_CLK_NS     = 8;
  localparam int          TOSC_CYCLES    = (TOSC_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [1:0]  Q_LAST         = 2'((4 * TOSC_CYCLES) - 1);

  typedef struct packed {
    logic [7:0] period;
    logic [1:0] prescale;
    logic       run;
  } timer_cfg_t;
endpackage : pwm_pkg

// ===== standard_pwm_generator.sv
`timescale 1ns/1ns
`default_nettype none
module standard_pwm_generator (
  // clock, reset, sleep freeze
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  // software writes
  input  wire logic                    i_ctrl_wr,
  input  wire logic [7:0]              i_ctrl_data,
  input  wire logic                    i_duty_high_wr,
  input  wire logic [7:0]              i_duty_high_data,
  input  wire logic                    i_active_duty_wr,
  input  wire logic [7:0]              i_active_duty_data,
  input  wire logic [1:0]              i_timer_select_field,
  input  wire pwm_pkg::timer_cfg_t [2:0] i_timer_cfg,
  input  wire logic [2:0]              i_flag_clr,
  input  wire logic                    i_pin_direction_bit,
  // pin and readback
  output logic                         o_pwm_output_pin,
  output logic                         o_pwm_oe_n,
  output logic [7:0]                   o_module_control_reg,
  output logic [7:0]                   o_duty_high_bits_reg,
  output logic [7:0]                   o_active_duty_buffer,
  output logic [2:0][7:0]              o_period_timer_count,
  output logic [2:0]                   o_timer_match_flag
);

  logic       rst_meta_n;
  logic       rst_n;
  logic [1:0] q_phase;
  logic [2:0] match_ev;
  logic [1:0] next_q_phase;
  logic [2:0][9:0] next_tb;
  logic [1:0] sel;
  logic [1:0] latch_lo;
  logic [9:0] active_duty;
  logic [9:0] pending_duty;
  logic [9:0] next_time_base;
  logic       rollover;
  logic       pwm_mode;
  logic [7:0] next_ctrl;
  logic       next_drive;

  // reset released through two flops; asserted at once
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // oscillator phase within one timer step; frozen in sleep
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_phase <= 2'h0;
    else
      q_phase <= next_q_phase;
  end

  // next phase, also used to look one clock ahead on the time base
  assign next_q_phase = !i_clk_en ? q_phase
                      : (q_phase == pwm_pkg::Q_LAST) ? 2'h0 : q_phase + 2'h1;

  // three period timers; the postscaler is not modelled at all
  genvar g;
  generate
    for (g = 0; g < pwm_pkg::NUM_TIMERS; g++)
    begin : g_timer
      logic [3:0] psc;
      logic [3:0] psc_last;
      logic       step;
      logic       psc_roll;
      logic [3:0] next_psc;
      logic [7:0] next_count;

      assign psc_last = (i_timer_cfg[g].prescale == pwm_pkg::PSC_DIV1) ? pwm_pkg::PSC_LAST_DIV1
                      : (i_timer_cfg[g].prescale == pwm_pkg::PSC_DIV4) ? pwm_pkg::PSC_LAST_DIV4
                      : pwm_pkg::PSC_LAST_DIV16;
      assign step     = i_clk_en && i_timer_cfg[g].run && (q_phase == pwm_pkg::Q_LAST);
      assign psc_roll = step && (psc >= psc_last);
      // the match event is the increment that follows count == period
      assign match_ev[g] = psc_roll && (o_period_timer_count[g] == i_timer_cfg[g].period);
      // values after this edge; the count clears on the match step
      assign next_psc   = !step ? psc : (psc_roll ? 4'h0 : psc + 4'h1);
      assign next_count = !psc_roll ? o_period_timer_count[g]
                        : match_ev[g] ? 8'h00 : o_period_timer_count[g] + 8'h01;
      // time base one clock ahead, so the registered pin falls in the cycle
      // the base reaches the duty rather than a clock late
      // low bits: clock phase at 1:1, else prescaler bits
      assign next_tb[g] = (i_timer_cfg[g].prescale == pwm_pkg::PSC_DIV1)
                        ? {next_count, next_q_phase}
                        : (i_timer_cfg[g].prescale == pwm_pkg::PSC_DIV4)
                        ? {next_count, next_psc[1:0]}
                        : {next_count, next_psc[3:2]};

      // prescaler and 8-bit count
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          psc                     <= 4'h0;
          o_period_timer_count[g] <= pwm_pkg::COUNT_RESET;
        end
        else
        begin
          psc                     <= next_psc;
          o_period_timer_count[g] <= next_count;
        end
      end

      // sticky match flag; a set in the clearing cycle wins
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          o_timer_match_flag[g] <= 1'b0;
        else if (match_ev[g])
          o_timer_match_flag[g] <= 1'b1;
        else if (i_clk_en && i_flag_clr[g])
          o_timer_match_flag[g] <= 1'b0;
      end
    end
  endgenerate

  // selection code 3 has no timer behind it and so never rolls over
  assign sel          = i_timer_select_field;
  assign rollover     = (sel < 2'h3) && match_ev[sel];
  assign next_time_base = (sel < 2'h3) ? next_tb[sel] : 10'h000;
  assign pwm_mode     = (o_module_control_reg[pwm_pkg::CTRL_MODE_LSB + 2 +: 2]
                         == pwm_pkg::MODE_PWM_TOP);
  assign active_duty  = {o_active_duty_buffer, latch_lo};
  // eight high bits from the duty register, two from control bits 5:4
  assign pending_duty = {o_duty_high_bits_reg,
                         o_module_control_reg[pwm_pkg::CTRL_DUTY_LSB +: 2]};
  assign next_ctrl    = (i_clk_en && i_ctrl_wr) ? i_ctrl_data : o_module_control_reg;
  // the pin is driven only in pwm mode with direction set to output
  assign next_drive   = (next_ctrl[pwm_pkg::CTRL_MODE_LSB + 2 +: 2] == pwm_pkg::MODE_PWM_TOP)
                        && !i_pin_direction_bit;

  // software-written registers; duty writes land at any clock with i_clk_en high
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_module_control_reg <= pwm_pkg::CTRL_RESET;
      o_duty_high_bits_reg <= pwm_pkg::DUTY_RESET;
    end
    else if (i_clk_en)
    begin
      o_module_control_reg <= next_ctrl;
      if (i_duty_high_wr)
        o_duty_high_bits_reg <= i_duty_high_data;
    end
  end

  // double buffer: in pwm mode loaded only at period end, so no mid-period glitch
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_active_duty_buffer <= pwm_pkg::DUTY_RESET;
      latch_lo             <= 2'h0;
    end
    else if (rollover)
    begin
      o_active_duty_buffer <= pending_duty[9:2];
      latch_lo             <= pending_duty[1:0];
    end
    else if (i_clk_en && i_active_duty_wr && !pwm_mode)
      o_active_duty_buffer <= i_active_duty_data;
  end

  // waveform: set at rollover, cleared at the edge where the time base reaches
  // the duty, so the high time is exactly duty steps; a duty past the
  // period never matches, so the level simply carries on
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_pwm_output_pin <= 1'b0;
    else if (i_clk_en && pwm_mode)
    begin
      if (rollover)
        o_pwm_output_pin <= (pending_duty != 10'h000);
      else if (next_time_base == active_duty)
        o_pwm_output_pin <= 1'b0;
    end
  end

  // pin enable, low while driving; reset leaves the pin an input
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_pwm_oe_n <= 1'b1;
    else if (i_clk_en)
      o_pwm_oe_n <= !next_drive;
  end

  // checks
  sequence s_period_end;
    i_clk_en && pwm_mode && rollover;
  endsequence

  sequence s_duty_hit;
    i_clk_en && pwm_mode && !rollover && (next_time_base == active_duty);
  endsequence

  a_rollover_sets_pin: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    s_period_end ##0 (pending_duty != 10'h000) |=> o_pwm_output_pin)
    else $error("pin not set at period end");

  a_zero_duty_low: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    s_period_end ##0 (pending_duty == 10'h000) |=> !o_pwm_output_pin)
    else $error("pin set with zero duty");

  a_duty_loaded: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    rollover |=> active_duty == $past(pending_duty))
    else $error("duty not latched at period end");

  a_match_clears: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    s_duty_hit |=> !o_pwm_output_pin)
    else $error("pin not cleared on duty match");

  a_duty_held_midperiod: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    pwm_mode && !rollover |=> $stable(active_duty))
    else $error("active duty changed inside period");

  a_sleep_freeze: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !i_clk_en |=> $stable(o_pwm_output_pin) && $stable(o_period_timer_count)
                  && $stable(q_phase))
    else $error("state moved while frozen");

  a_wrap_to_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    s_period_end |=> o_period_timer_count[$past(sel)] == 8'h00)
    else $error("timer not cleared after period match");

  a_pin_release: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_clk_en && i_ctrl_wr && (i_ctrl_data == 8'h00) |=> o_pwm_oe_n)
    else $error("pin still driven after control cleared");

  a_pin_drive: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_clk_en && !i_ctrl_wr && pwm_mode && !i_pin_direction_bit |=> !o_pwm_oe_n)
    else $error("pin not driven in pwm mode");

  a_flag_sets: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    match_ev[0] |=> o_timer_match_flag[0] ##1 (o_timer_match_flag[0] || $past(i_flag_clr[0])))
    else $error("match flag not set");

endmodule : standard_pwm_generator
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, dir = 1'b1;
  logic c_wr = 1'b0, d_wr = 1'b0, a_wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] tsel = 2'h1;
  logic [2:0] fclr = 3'h0;
  pwm_pkg::timer_cfg_t [2:0] tcfg = '0;
  logic pin, oe_n, lvl, rise;
  logic [7:0] ctrl, dhigh, dact;
  logic [2:0][7:0] cnt;
  logic [2:0] flag;
  logic [15:0] hw, per;
  logic acc;
  logic [7:0] held;
  int fail_count = 0, checked = 0, cycles = 0;
  always #4 clk = ~clk;
  standard_pwm_generator u_standard_pwm_generator (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_clk_en(clk_en), .i_ctrl_wr(c_wr), .i_ctrl_data(wdata), .i_duty_high_wr(d_wr),
    .i_duty_high_data(wdata), .i_active_duty_wr(a_wr), .i_active_duty_data(wdata),
    .i_timer_select_field(tsel), .i_timer_cfg(tcfg), .i_flag_clr(fclr),
    .i_pin_direction_bit(dir), .o_pwm_output_pin(pin), .o_pwm_oe_n(oe_n),
    .o_module_control_reg(ctrl), .o_duty_high_bits_reg(dhigh),
    .o_active_duty_buffer(dact), .o_period_timer_count(cnt), .o_timer_match_flag(flag));
  pwm_load u_pwm_load (.i_sys_clk(clk), .i_pwm_output_pin(pin), .i_pwm_oe_n(oe_n),
    .o_level(lvl), .o_rise(rise), .o_high_cycles(hw), .o_period_cycles(per));
  task automatic conclude();
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle: 0 control, 1 duty high, 2 active buffer
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    #1 wdata = d;
    c_wr = (sel == 0);
    d_wr = (sel == 1);
    a_wr = (sel == 2);
    @(posedge clk);
    #1 {c_wr, d_wr, a_wr} = 3'h0;
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait for rising pin edges seen by the load
  task automatic rises(input int n);
    int k;
    repeat (n)
    begin
      for (k = 0; k < 2000; k++)
      begin
        @(posedge clk);
        #1;
        if (rise === 1'b1) break;
      end
      if (k == 2000) check(16'h0000, 16'h0001);
    end
  endtask : rises
  // pin held at one level across one whole period of 16 clocks
  task automatic flat(input logic exp);
    acc = exp;
    cyc(40);
    repeat (16)
    begin
      cyc(1);
      if (pin !== exp) acc = ~exp;
    end
    check(acc, exp);
  endtask : flat
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    tcfg[0] = '{period: 8'h07, prescale: 2'h0, run: 1'b1};
    tcfg[2] = '{period: 8'h01, prescale: 2'h2, run: 1'b1};
    cyc(20);
    rst_n = 1'b1;
    cyc(3);
    check({pin, oe_n, ctrl, flag[1]}, {2'b01, 8'h00, 1'b0});
    check({dhigh, dact}, 16'h0000);
    check(cnt[1], 8'h00);
    // setup order: pin off, period, mode, duty, flag, run
    tcfg[1].period = 8'h03;
    wr(0, 8'h2C);
    wr(1, 8'h02);
    check(ctrl, 8'h2C);
    fclr = 3'h2;
    cyc(1);
    fclr = 3'h0;
    check(flag[1], 1'b0);
    tcfg[1].run = 1'b1;
    cyc(20);
    check(flag[1], 1'b1);
    fclr = 3'h2;
    cyc(1);
    fclr = 3'h0;
    check(flag[1], 1'b0);
    check(oe_n, 1'b1);
    dir = 1'b0;
    cyc(2);
    check(oe_n, 1'b0);
    rises(3);
    check(per, 16'h0010);
    check(hw, 16'h000A);
    check(dact, 8'h02);
    wr(2, 8'hAA);
    cyc(1);
    check(dact, 8'h02);
    rises(1);
    wr(1, 8'h01);
    check(dact, 8'h02);
    rises(3);
    check(dact, 8'h01);
    check(hw, 16'h0006);
    wr(1, 8'h00);
    wr(0, 8'h0C);
    flat(1'b0);
    wr(1, 8'h10);
    flat(1'b1);
    tcfg[1].prescale = pwm_pkg::PSC_DIV4;
    wr(1, 8'h01);
    wr(0, 8'h2C);
    rises(3);
    check(per, 16'h0040);
    check(hw, 16'h0018);
    // third timer: period 1 at 1:16, same duty of 6
    tsel = 2'h2;
    rises(3);
    check(per, 16'h0080);
    check(hw, 16'h0060);
    clk_en = 1'b0;
    cyc(1);
    held = cnt[1];
    acc = pin;
    wr(0, 8'h00);
    cyc(20);
    check({cnt[1], ctrl}, {held, 8'h2C});
    check(pin, acc);
    clk_en = 1'b1;
    wr(0, 8'h00);
    cyc(2);
    check({oe_n, ctrl}, {1'b1, 8'h00});
    conclude();
  end
endmodule : tb_top
`default_nettype wire
